// ### hw/dhp_pkg.sv
package dhp_pkg;

   // ----------------------------------------------------------------
   // register addresses on the four-bit host address
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_STAT_A   = 4'h1;
   localparam logic [3:0] ADDR_STAT_B   = 4'h9;
   localparam logic [3:0] ADDR_IRQ      = 4'h5;
   localparam logic [3:0] ADDR_IPORT    = 4'hD;
   localparam logic [3:0] ADDR_OPCFG    = 4'hD;
   localparam logic [3:0] ADDR_OP_SET   = 4'hE;
   localparam logic [3:0] ADDR_OP_CLR   = 4'hF;
   localparam logic [3:0] ADDR_CLKSEL   = 4'h2;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CLEAR     = 8'h00;
   localparam logic [7:0] PINS_HIGH     = 8'hFF;
   localparam int         ISR_TX_A      = 0;
   localparam int         ISR_RX_A      = 1;
   localparam int         ISR_TX_B      = 4;
   localparam int         ISR_RX_B      = 5;
   localparam int         CFG_OP4       = 4;
   localparam int         CFG_OP5       = 5;
   localparam int         CFG_OP6       = 6;
   localparam int         CFG_OP7       = 7;
   localparam int         SEL_TXC_A     = 0;
   localparam int         SEL_RXC_A     = 1;
   localparam int         SEL_TXC_B     = 2;
   localparam int         SEL_RXC_B     = 3;
   localparam int         SEL_CT_EXT    = 4;
   localparam int         SEL_CTS_A     = 5;
   localparam int         SEL_CTS_B     = 6;
   localparam int         SYNC_STAGES   = 2;

   // host bus cycle phases
   typedef enum logic [1:0] {
      DHP_IDLE,
      DHP_ACK,
      DHP_WAIT
   } dhp_state_t;

   // pin bundle carried as one unit
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } dhp_bus_t;

endpackage : dhp_pkg

// ### hw/dhp_top.sv
`timescale 1ns/1ns
// How it works
// - bus-select high picks acknowledge-style bus
// - eight-bit tri-state data bus, bit 0 lsb
// - chip select high floats data bus
// - acknowledge low during every transfer cycle
// - four-bit address selects register
// - reset clears status, mask, port, config
// - reset drives outputs high, halts timer
// - reset idles channels, serial outputs high
// - irq pin low when masked condition true
// - inputs 0,1 also clear-to-send a, b
// - input 2 also counter external clock
// - external transmit clock shifts on falling edge
// - external receive clock samples on rising edge
// - output 7 may show channel b tx irq
// - outputs 4,5,6 may show irq bits 1,5,0
module dhp_top (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       bus_select,
   input  wire logic       chip_select_n,
   input  wire logic       read_write_n,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic      [7:0] data_oe,
   output logic            transfer_ack_n,
   output logic            irq_request_n_oe,
   input  wire logic [6:0] in_pins,
   input  wire logic [7:0] irq_events,
   input  wire logic [7:0] chan_status_a,
   input  wire logic [7:0] chan_status_b,
   input  wire logic       tx_bit_a,
   input  wire logic       tx_bit_b,
   output logic      [7:0] out_pins,
   output logic      [7:0] out_pins_od_oe,
   output logic            tx_serial_out_a,
   output logic            tx_serial_out_b,
   output logic            tx_shift_a,
   output logic            tx_shift_b,
   output logic            rx_sample_a,
   output logic            rx_sample_b,
   output logic            timer_tick,
   output logic            timer_run,
   output logic            clear_to_send_a_n,
   output logic            clear_to_send_b_n
);

   // ----------------------------------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic [6:0]  s1_r;
   logic [6:0]  s2_r;
   // select and direction wake up at their idle high level
   localparam logic [6:0] SYNC_IDLE = 7'h30;
   logic [6:0]  ip_prev_r;

   // reset released only after two clean edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rst_sync_r <= 2'b00;
      else          rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // two-stage capture of the bus select, direction and address inputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= SYNC_IDLE;
         s2_r <= SYNC_IDLE;
      end else begin
         s1_r <= {bus_select, chip_select_n, read_write_n, addr};
         s2_r <= s1_r;
      end
   end

   logic [6:0] ip_s;
   logic [6:0] ip2_s;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ip2_s     <= 7'h00;
         ip_s      <= 7'h00;
         ip_prev_r <= 7'h00;
      end else begin
         ip2_s     <= in_pins;
         ip_s      <= ip2_s;
         ip_prev_r <= ip_s;
      end
   end

   logic       bsel_s;
   logic       cs_n_s;
   logic       rw_s;
   logic [3:0] addr_s;
   assign bsel_s = s2_r[6];
   assign cs_n_s = s2_r[5];
   assign rw_s   = s2_r[4];
   assign addr_s = s2_r[3:0];

   // ----------------------------------------------------------------
   // host cycle sequencing
   // ----------------------------------------------------------------
   dhp_pkg::dhp_state_t st_r;
   dhp_pkg::dhp_state_t st_nxt;
   logic cyc_start;
   logic do_write;
   logic do_read;

   // a cycle opens once select is low on the acknowledge bus
   assign cyc_start = (st_r == dhp_pkg::DHP_IDLE) && !cs_n_s && bsel_s;
   assign do_write  = cyc_start && !rw_s;
   assign do_read   = cyc_start && rw_s;

   always_comb begin
      case (st_r)
         dhp_pkg::DHP_IDLE: st_nxt = cyc_start ? dhp_pkg::DHP_ACK
                                               : dhp_pkg::DHP_IDLE;
         dhp_pkg::DHP_ACK:  st_nxt = dhp_pkg::DHP_WAIT;
         dhp_pkg::DHP_WAIT: st_nxt = cs_n_s ? dhp_pkg::DHP_IDLE
                                            : dhp_pkg::DHP_WAIT;
         default:           st_nxt = dhp_pkg::DHP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)   st_r <= dhp_pkg::DHP_IDLE;
      else if (!rst_n) st_r <= dhp_pkg::DHP_IDLE;
      else            st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // host-visible registers
   // ----------------------------------------------------------------
   logic [7:0] imr_r;
   logic [7:0] isr_r;
   logic [7:0] opr_r;
   logic [7:0] output_port_config_reg_r;
   logic [7:0] clksel_r;
   logic [7:0] sra_r;
   logic [7:0] srb_r;
   logic [7:0] isr_nxt;
   logic       wr_imr;
   logic       wr_output_port_config_reg;
   logic       wr_set;
   logic       wr_clr;
   logic       wr_sel;
   logic       rd_isr;

   // address decode of the write strobes
   assign wr_imr  = do_write && addr_s == dhp_pkg::ADDR_IRQ;
   assign wr_output_port_config_reg = do_write && addr_s == dhp_pkg::ADDR_OPCFG;
   assign wr_set  = do_write && addr_s == dhp_pkg::ADDR_OP_SET;
   assign wr_clr  = do_write && addr_s == dhp_pkg::ADDR_OP_CLR;
   assign wr_sel  = do_write && addr_s == dhp_pkg::ADDR_CLKSEL;
   assign rd_isr  = do_read  && addr_s == dhp_pkg::ADDR_IRQ;
   // events stay sticky until the status is read; set beats clear
   assign isr_nxt = (rd_isr ? dhp_pkg::REG_CLEAR : isr_r) | irq_events;

   // all these clear while reset is held
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         imr_r    <= dhp_pkg::REG_CLEAR;
         isr_r    <= dhp_pkg::REG_CLEAR;
         opr_r    <= dhp_pkg::REG_CLEAR;
         output_port_config_reg_r   <= dhp_pkg::REG_CLEAR;
         clksel_r <= dhp_pkg::REG_CLEAR;
         sra_r    <= dhp_pkg::REG_CLEAR;
         srb_r    <= dhp_pkg::REG_CLEAR;
      end else begin
         if (wr_imr)  imr_r    <= data_in;
         if (wr_output_port_config_reg) output_port_config_reg_r   <= data_in;
         if (wr_sel)  clksel_r <= data_in;
         if (wr_set)  opr_r    <= opr_r | data_in;
         else if (wr_clr) opr_r <= opr_r & ~data_in;
         isr_r <= isr_nxt;
         sra_r <= chan_status_a;
         srb_r <= chan_status_b;
      end
   end

   logic [7:0] rd_mux;
   assign rd_mux =
      (addr_s == dhp_pkg::ADDR_STAT_A) ? sra_r :
      (addr_s == dhp_pkg::ADDR_STAT_B) ? srb_r :
      (addr_s == dhp_pkg::ADDR_IRQ)    ? isr_r :
      (addr_s == dhp_pkg::ADDR_IPORT)  ? {1'b0, ip_s} :
                                         dhp_pkg::REG_CLEAR;

   // ----------------------------------------------------------------
   // data bus drive and acknowledge
   // ----------------------------------------------------------------
   dhp_pkg::dhp_bus_t bus_r;
   logic              ack_r;

   // drive only during an open read; float as soon as select rises
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_r <= '0;
         ack_r <= 1'b1;
      end else begin
         if (do_read) bus_r <= '{data: rd_mux, oe: 8'hFF};
         else if (cs_n_s || !rw_s) bus_r.oe <= 8'h00;
         ack_r <= !((st_nxt != dhp_pkg::DHP_IDLE) && !cs_n_s);
      end
   end
   assign data_out       = bus_r.data;
   assign data_oe        = bus_r.oe;
   assign transfer_ack_n = ack_r;

   // ----------------------------------------------------------------
   // interrupt pin and output port
   // ----------------------------------------------------------------
   logic       irq_r;
   logic [7:0] op_r;
   logic [7:0] op_od_r;
   logic [7:0] op_val;
   logic [7:0] op_odv;

   // port bit set means pin low, so reset value gives high pins
   assign op_val = ~opr_r;
   assign op_odv = {output_port_config_reg_r[dhp_pkg::CFG_OP7] & isr_r[dhp_pkg::ISR_TX_B],
                    output_port_config_reg_r[dhp_pkg::CFG_OP6] & isr_r[dhp_pkg::ISR_TX_A],
                    output_port_config_reg_r[dhp_pkg::CFG_OP5] & isr_r[dhp_pkg::ISR_RX_B],
                    output_port_config_reg_r[dhp_pkg::CFG_OP4] & isr_r[dhp_pkg::ISR_RX_A],
                    4'h0};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_r   <= 1'b0;
         op_r    <= dhp_pkg::PINS_HIGH;
         op_od_r <= dhp_pkg::REG_CLEAR;
      end else begin
         irq_r   <= |(isr_r & imr_r);
         op_r    <= {output_port_config_reg_r[7:4] & 4'h0 | op_val[7:4] & ~output_port_config_reg_r[7:4],
                     op_val[3:0]};
         op_od_r <= op_odv;
      end
   end
   assign irq_request_n_oe = irq_r;
   assign out_pins         = op_r;
   assign out_pins_od_oe   = op_od_r;

   // ----------------------------------------------------------------
   // alternate input functions and serial idle
   // ----------------------------------------------------------------
   logic [6:0] rise;
   logic [6:0] fall;
   assign rise = ip_s & ~ip_prev_r;
   assign fall = ~ip_s & ip_prev_r;

   logic tsa_r, tsb_r, rsa_r, rsb_r, tick_r, run_r;
   logic txa_r, txb_r, ctsa_r, ctsb_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tsa_r  <= 1'b0;
         tsb_r  <= 1'b0;
         rsa_r  <= 1'b0;
         rsb_r  <= 1'b0;
         tick_r <= 1'b0;
         run_r  <= 1'b0;
         txa_r  <= 1'b1;
         txb_r  <= 1'b1;
         ctsa_r <= 1'b1;
         ctsb_r <= 1'b1;
      end else begin
         tsa_r  <= clksel_r[dhp_pkg::SEL_TXC_A] & fall[3];
         tsb_r  <= clksel_r[dhp_pkg::SEL_TXC_B] & fall[5];
         rsa_r  <= clksel_r[dhp_pkg::SEL_RXC_A] & rise[4];
         rsb_r  <= clksel_r[dhp_pkg::SEL_RXC_B] & rise[6];
         tick_r <= clksel_r[dhp_pkg::SEL_CT_EXT] & rise[2];
         run_r  <= rst_n;
         txa_r  <= rst_n ? tx_bit_a : 1'b1;
         txb_r  <= rst_n ? tx_bit_b : 1'b1;
         ctsa_r <= clksel_r[dhp_pkg::SEL_CTS_A] ? ip_s[0] : 1'b1;
         ctsb_r <= clksel_r[dhp_pkg::SEL_CTS_B] ? ip_s[1] : 1'b1;
      end
   end
   assign tx_shift_a        = tsa_r;
   assign tx_shift_b        = tsb_r;
   assign rx_sample_a       = rsa_r;
   assign rx_sample_b       = rsb_r;
   assign timer_tick        = tick_r;
   assign timer_run         = run_r;
   assign tx_serial_out_a   = txa_r;
   assign tx_serial_out_b   = txb_r;
   assign clear_to_send_a_n = ctsa_r;
   assign clear_to_send_b_n = ctsb_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_float_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      $past(cs_n_s) && $past(st_r) != dhp_pkg::DHP_IDLE |-> data_oe == 0)
      else $error("bus driven while deselected");
   chk_ack_cycle: assert property (
      @(posedge clk) disable iff (!reset_n)
      cyc_start |=> !transfer_ack_n)
      else $error("no acknowledge on cycle");
   chk_read_drive: assert property (
      @(posedge clk) disable iff (!reset_n)
      do_read |=> data_oe == 8'hFF && data_out == $past(rd_mux))
      else $error("read data not driven");
   chk_irq_pin: assert property (
      @(posedge clk) disable iff (!reset_n)
      (|(isr_r & imr_r)) |=> irq_request_n_oe)
      else $error("irq not raised");
   chk_tx_fall: assert property (
      @(posedge clk) disable iff (!reset_n)
      clksel_r[dhp_pkg::SEL_TXC_A] && fall[3] |=> tx_shift_a)
      else $error("tx shift missed");
   chk_rx_rise: assert property (
      @(posedge clk) disable iff (!reset_n)
      clksel_r[dhp_pkg::SEL_RXC_B] && rise[6] |=> rx_sample_b)
      else $error("rx sample missed");
   chk_op7_irq: assert property (
      @(posedge clk) disable iff (!reset_n)
      output_port_config_reg_r[dhp_pkg::CFG_OP7] && isr_r[dhp_pkg::ISR_TX_B]
      |=> out_pins_od_oe[7])
      else $error("op7 irq not shown");
   chk_reset_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      !rst_n |=> tx_serial_out_a && tx_serial_out_b && !timer_run)
      else $error("channels not idle in reset");
   chk_wr_decode: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_imr |=> imr_r == $past(data_in))
      else $error("mask write lost");

endmodule : dhp_top

// ### testbench/dhp_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// host cpu on the acknowledge-style parallel bus
// ------------------------------------------------------------------
module dhp_host_model (
   input  wire logic       clk,
   input  wire logic       transfer_ack_n,
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe,
   output logic            chip_select_n,
   output logic            read_write_n,
   output logic      [3:0] addr,
   output logic      [7:0] data_in
);
   initial begin
      chip_select_n = 1'b1;
      read_write_n  = 1'b1;
      addr          = 4'h0;
      data_in       = 8'h00;
   end

   // one cycle: hold everything until ack is sampled low or 12 clocks pass, then release
   task automatic cycle(input logic rd, input logic [3:0] a,
                        input logic [7:0] wd, output logic [7:0] rdata,
                        output logic ok);
      int n;
      ok    = 1'b0;
      rdata = 8'h00;
      n     = 0;
      @(negedge clk);
      chip_select_n = 1'b0;
      read_write_n  = rd;
      addr          = a;
      data_in       = wd;
      while (n < 12 && !ok) begin
         @(posedge clk);
         ok = (transfer_ack_n === 1'b0);
         n++;
      end
      // on a read, a bus that is not driven reads as garbage, never as data
      if (ok)
         rdata = (data_oe === (rd ? 8'hFF : 8'h00)) ? data_out : 8'hxx;
      @(negedge clk);
      chip_select_n = 1'b1;
      read_write_n  = 1'b1;
      data_in       = ~wd;                // released lines do not hold
      n = 0;
      while (n < 12 && transfer_ack_n !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      if (transfer_ack_n !== 1'b1)
         ok = 1'b0;
      repeat (2) @(negedge clk);          // idle gap before next cycle
   endtask : cycle
endmodule : dhp_host_model

// ### testbench/test_dual_uart_host_bus_and_pin_functions.sv
`timescale 1ns/1ns
module test_dual_uart_host_bus_and_pin_functions;
   logic       clk = 1'b0, reset_n = 1'b0, bus_select = 1'b1;
   logic       chip_select_n, read_write_n, transfer_ack_n, irq_request_n_oe;
   logic [3:0] addr;
   logic [7:0] data_in, data_out, data_oe, out_pins, out_pins_od_oe;
   logic [6:0] in_pins = 7'h03;
   logic [7:0] irq_events = 8'h00;
   logic [1:0] tx_bits = 2'b00;
   logic       tx_serial_out_a, tx_serial_out_b, timer_tick, timer_run;
   logic       tx_shift_a, tx_shift_b, rx_sample_a, rx_sample_b;
   logic       clear_to_send_a_n, clear_to_send_b_n, ok;
   logic [7:0] rv;
   int         fails = 0, comparisons = 0, cnt [5];
   typedef struct packed {
      logic       rd;
      logic [3:0] a;
      logic [7:0] wd;
      logic [7:0] exp;
   } dhp_tb_row_t;
   dhp_tb_row_t rows [5];

   always #10 clk = ~clk;

   dhp_top dut_u (.clk(clk), .reset_n(reset_n), .bus_select(bus_select),
      .chip_select_n(chip_select_n), .read_write_n(read_write_n),
      .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .transfer_ack_n(transfer_ack_n),
      .irq_request_n_oe(irq_request_n_oe), .in_pins(in_pins),
      .irq_events(irq_events), .chan_status_a(8'h5A),
      .chan_status_b(8'hA5), .tx_bit_a(tx_bits[1]), .tx_bit_b(tx_bits[0]),
      .out_pins(out_pins), .out_pins_od_oe(out_pins_od_oe),
      .tx_serial_out_a(tx_serial_out_a), .tx_serial_out_b(tx_serial_out_b),
      .tx_shift_a(tx_shift_a), .tx_shift_b(tx_shift_b),
      .rx_sample_a(rx_sample_a), .rx_sample_b(rx_sample_b),
      .timer_tick(timer_tick), .timer_run(timer_run),
      .clear_to_send_a_n(clear_to_send_a_n),
      .clear_to_send_b_n(clear_to_send_b_n));

   dhp_host_model host_u (.clk(clk), .transfer_ack_n(transfer_ack_n),
      .data_out(data_out), .data_oe(data_oe),
      .chip_select_n(chip_select_n), .read_write_n(read_write_n),
      .addr(addr), .data_in(data_in));

   // ------------------------------------------------------------------
   // pulse counters for the external clock strobes
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (tx_shift_a === 1'b1) cnt[0]++;
      if (rx_sample_a === 1'b1) cnt[1]++;
      if (tx_shift_b === 1'b1) cnt[2]++;
      if (rx_sample_b === 1'b1) cnt[3]++;
      if (timer_tick === 1'b1) cnt[4]++;
   end

   task automatic check(input string what, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // bus cycle that must be acknowledged
   task automatic bus(input logic rd, input logic [3:0] a,
                      input logic [7:0] wd);
      host_u.cycle(rd, a, wd, rv, ok);
      check("ack seen", {7'h00, ok}, 8'h01);
      check("bus idle oe", data_oe, 8'h00);
   endtask : bus

   // reset, held 12 cycles, with the pins checked inside it
   task automatic do_reset();
      @(negedge clk);
      reset_n = 1'b0;
      repeat (12) @(negedge clk);
      check("oe in reset", data_oe, 8'h00);
      check("irq in reset", {7'h00, irq_request_n_oe}, 8'h00);
      check("pins in reset", out_pins, dhp_pkg::PINS_HIGH);
      check("timer in reset", {7'h00, timer_run}, 8'h00);
      check("tx in reset", {6'h00, tx_serial_out_a, tx_serial_out_b},
            8'h03);
      check("ack in reset", {7'h00, transfer_ack_n}, 8'h01);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      check("timer run", {7'h00, timer_run}, 8'h01);
      check("tx follows", {6'h00, tx_serial_out_a, tx_serial_out_b},
            {6'h00, tx_bits});
      check("pins after", out_pins, dhp_pkg::PINS_HIGH);
   endtask : do_reset

   task automatic pulse(input logic [7:0] ev);
      @(negedge clk);
      irq_events = ev;
      @(negedge clk);
      irq_events = 8'h00;
      repeat (5) @(negedge clk);
   endtask : pulse

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up();
   end

   initial begin
      rows[0] = {1'b1, dhp_pkg::ADDR_STAT_A, 8'h00, 8'h5A};
      rows[1] = {1'b1, dhp_pkg::ADDR_STAT_B, 8'h00, 8'hA5};
      rows[2] = {1'b1, 4'h3, 8'h00, 8'h00};
      rows[3] = {1'b0, dhp_pkg::ADDR_OP_SET, 8'h0F, 8'hF0};
      rows[4] = {1'b0, dhp_pkg::ADDR_OP_CLR, 8'h05, 8'hF5};
      do_reset();
      // ----------------------------------------------------------------
      // ordinary reads and writes from the table
      // ----------------------------------------------------------------
      foreach (rows[i]) begin
         bus(rows[i].rd, rows[i].a, rows[i].wd);
         if (rows[i].rd)
            check("read data", rv, rows[i].exp);
         else
            check("out pins", out_pins, rows[i].exp);
      end
      // ----------------------------------------------------------------
      // awkward cases
      // ----------------------------------------------------------------
      bus_select = 1'b0;
      host_u.cycle(1'b1, dhp_pkg::ADDR_STAT_A, 8'h00, rv, ok);
      check("refused ack", {7'h00, ok}, 8'h00);
      check("refused oe", data_oe, 8'h00);
      bus_select = 1'b1;
      // masked event leaves irq released, shows on pin 4
      bus(1'b0, dhp_pkg::ADDR_IRQ, 8'h01);
      pulse(8'h02);
      check("irq masked", {7'h00, irq_request_n_oe}, 8'h00);
      bus(1'b0, dhp_pkg::ADDR_OPCFG, 8'hF0);
      check("od pin4", out_pins_od_oe, 8'h10);
      pulse(8'h11);
      check("irq raised", {7'h00, irq_request_n_oe}, 8'h01);
      check("od pins", out_pins_od_oe, 8'hD0);
      bus(1'b1, dhp_pkg::ADDR_IRQ, 8'h00);
      check("irq status", rv, 8'h13);
      repeat (4) @(negedge clk);
      check("irq cleared", {7'h00, irq_request_n_oe}, 8'h00);
      check("od cleared", out_pins_od_oe, 8'h00);
      // clear-to-send follows pins 0 and 1 only when selected
      bus(1'b0, dhp_pkg::ADDR_CLKSEL, 8'h60);
      in_pins[0] = 1'b0;
      repeat (5) @(negedge clk);
      check("cts on", {6'h00, clear_to_send_a_n, clear_to_send_b_n},
            8'h01);
      bus(1'b0, dhp_pkg::ADDR_CLKSEL, 8'h1F);
      check("cts off", {6'h00, clear_to_send_a_n, clear_to_send_b_n},
            8'h03);
      // transmit clocks act on the fall, receive clocks on the rise
      for (int i = 0; i < 4; i++) begin
         cnt[i] = 0;
         in_pins[3 + i] = 1'b1;
         repeat (6) @(negedge clk);
         check("strobe rise", cnt[i][7:0], {7'h00, i[0]});
         in_pins[3 + i] = 1'b0;
         repeat (6) @(negedge clk);
         check("strobe fall", cnt[i][7:0], 8'h01);
      end
      // external counter clock on pin 2 gives one tick per rise
      cnt[4] = 0;
      in_pins[2] = 1'b1;
      repeat (6) @(negedge clk);
      in_pins[2] = 1'b0;
      repeat (6) @(negedge clk);
      check("timer tick", cnt[4][7:0], 8'h01);
      // mid-run reset with irq pending wipes status, mask and port
      pulse(8'h01);
      check("irq pending", {7'h00, irq_request_n_oe}, 8'h01);
      do_reset();
      bus(1'b1, dhp_pkg::ADDR_IRQ, 8'h00);
      check("status wiped", rv, 8'h00);
      pulse(8'h01);
      check("mask wiped", {7'h00, irq_request_n_oe}, 8'h00);
      wrap_up();
   end
endmodule : test_dual_uart_host_bus_and_pin_functions
